// file: core/apu_top.sv
`timescale 1ns/1ps

// Summary of operation
// - enabled unit starts a four-bit idle counter on pld clock periods
// - fifteen idle pld clock periods raise the power-down flag
// - enabling the unit also enables power-down entry
// - strobe pulsing again returns the device to normal mode
// - chip select low or reset high also leaves power-down
// - power-down blocks mcu bus from memories and pld address inputs, deselects memories
// - pld clock blocking never stops the idle counter clock
// - memories in standby during power-down; pld and ports stay active
// - gpio and pld pins follow live outputs, address out undefined, data and periph tri-state
// - pld behaviour follows turbo only; no memory access while down
// - power mode reg zero bit 3 set turns turbo off
// - turbo off: standby after 70ns quiet, slower below 15 MHz input rate
// - chip select high disables flash and sram, pld and io stay alive
// - reg zero bits 4 and 5 cut pld clock from and-array or macrocells
// - reg two bits 0,2..6 cut address, controls, strobe, byte enable
// - counter idle when disabled or pulsing; counts at polarity level

module apu_top
    import apu_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       address_strobe_in_i,
    input  wire logic       pld_clock_input_i,
    input  wire logic       chip_select_n_i,
    input  wire logic [7:0] mcu_addr_low_i,
    input  wire logic [7:0] mcu_data_i,
    input  wire logic       control_input_zero_i,
    input  wire logic       control_input_one_i,
    input  wire logic       control_input_two_i,
    input  wire logic       byte_enable_input_i,
    input  wire logic       auto_powerdown_enable_bit_i,
    input  wire logic       strobe_idle_polarity_i,
    input  wire logic [7:0] power_mode_reg_zero_i,
    input  wire logic [7:0] power_mode_reg_two_i,
    input  wire logic       primary_flash_req_i,
    input  wire logic       secondary_flash_req_i,
    input  wire logic       sram_req_i,
    input  wire logic       data_drive_i,
    input  wire logic [7:0] mem_rdata_i,
    input  wire logic       periph_drive_i,
    input  wire logic [7:0] periph_out_i,
    input  wire logic [7:0] latched_addr_i,
    input  wire logic [7:0] gpio_out_i,
    input  wire logic [7:0] pld_out_i,
    output logic            powerdown_flag_o,
    output logic [3:0]      idle_count_o,
    output logic [7:0]      mem_addr_o,
    output logic [7:0]      mem_data_o,
    output logic            primary_flash_sel_o,
    output logic            secondary_flash_sel_o,
    output logic            sram_sel_o,
    output logic            mem_standby_o,
    output logic [7:0]      pld_addr_low_o,
    output logic            pld_control_zero_o,
    output logic            pld_control_one_o,
    output logic            pld_control_two_o,
    output logic            pld_strobe_o,
    output logic            pld_byte_enable_o,
    output logic            pld_and_clock_o,
    output logic            pld_mcell_clock_o,
    output logic            pld_turbo_off_o,
    output logic            pld_standby_o,
    output logic            pld_slow_delay_o,
    output logic [7:0]      data_port_out_o,
    output logic            data_port_oe_n_o,
    output logic [7:0]      periph_io_out_o,
    output logic            periph_io_oe_n_o,
    output logic [7:0]      address_out_o,
    output logic [7:0]      gpio_pin_o,
    output logic [7:0]      pld_pin_o
);

    // ==========================================================
    // helpers
    // ==========================================================
    // blocked inputs freeze at their last value, so the far side
    // sees no transitions and can stay in standby
    function automatic logic [7:0] gate_byte(
        input logic       blocked,
        input logic [7:0] live,
        input logic [7:0] held
    );
        gate_byte = blocked ? held : live;
    endfunction

    function automatic logic gate_bit(
        input logic blocked,
        input logic live,
        input logic held
    );
        gate_bit = blocked ? held : live;
    endfunction

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    // pld clock is sampled, not used as a clock: it must run below
    // half of mclk for every period to be seen
    logic [2:0]  pin1_q;
    logic [2:0]  pin1_d;
    logic [2:0]  pin2_q;
    logic [2:0]  pin2_d;
    logic [1:0]  pin3_q;
    logic [1:0]  pin3_d;
    logic [19:0] bus1_q;
    logic [19:0] bus1_d;
    logic [19:0] bus2_q;
    logic [19:0] bus2_d;

    always_comb begin
        pin1_d = {chip_select_n_i, pld_clock_input_i,
                  address_strobe_in_i};
        pin2_d = pin1_q;
        pin3_d = pin2_q[1:0];
        bus1_d = {control_input_two_i, control_input_one_i,
                  control_input_zero_i, byte_enable_input_i,
                  mcu_data_i, mcu_addr_low_i};
        bus2_d = bus1_q;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pin1_q <= PIN_SYNC_RESET;
            pin2_q <= PIN_SYNC_RESET;
            pin3_q <= PIN_EDGE_RESET;
            bus1_q <= BUS_SYNC_RESET;
            bus2_q <= BUS_SYNC_RESET;
        end else begin
            pin1_q <= pin1_d;
            pin2_q <= pin2_d;
            pin3_q <= pin3_d;
            bus1_q <= bus1_d;
            bus2_q <= bus2_d;
        end
    end

    logic       strobe_s;
    logic       strobe_edge;
    logic       pclk_s;
    logic       pclk_tick;
    logic       cs_low;
    logic [7:0] addr_s;
    logic [7:0] data_s;
    logic [2:0] ctrl_s;
    logic       benable_s;

    assign strobe_s    = pin2_q[0];
    assign strobe_edge = pin2_q[0] ^ pin3_q[0];
    assign pclk_s      = pin2_q[1];
    assign pclk_tick   = pin2_q[1] & ~pin3_q[1];
    assign cs_low      = ~pin2_q[2];
    assign addr_s      = bus2_q[7:0];
    assign data_s      = bus2_q[15:8];
    assign benable_s   = bus2_q[16];
    assign ctrl_s      = bus2_q[19:17];

    // ==========================================================
    // idle counter
    // ==========================================================
    logic       idle_clear;
    logic       idle_full;
    logic [3:0] idle_count;
    logic       at_rest;

    assign at_rest    = (strobe_s == strobe_idle_polarity_i) & ~strobe_edge;
    assign idle_clear = ~auto_powerdown_enable_bit_i | ~at_rest | cs_low;

    apu_idle_cnt u_idle_cnt (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .clear_i (idle_clear),
        .tick_i  (pclk_tick),
        .count_o (idle_count),
        .full_o  (idle_full)
    );

    // ==========================================================
    // power-down mode
    // ==========================================================
    apu_mode_e mode_q;
    apu_mode_e mode_d;
    logic      pd_q;
    logic      pd_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            APU_RUN: begin
                if (auto_powerdown_enable_bit_i && idle_full && at_rest
                    && !cs_low) begin
                    mode_d = APU_DOWN;
                end
            end
            APU_DOWN: begin
                if (strobe_edge || cs_low || !auto_powerdown_enable_bit_i) begin
                    mode_d = APU_RUN;
                end
            end
            default: begin
                mode_d = APU_RUN;
            end
        endcase
        pd_d  = (mode_d == APU_DOWN);
        cnt_d = idle_count;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= APU_RUN;
            pd_q   <= BIT_RESET;
            cnt_q  <= IDLE_RESET;
        end else begin
            mode_q <= mode_d;
            pd_q   <= pd_d;
            cnt_q  <= cnt_d;
        end
    end

    assign powerdown_flag_o = pd_q;
    assign idle_count_o     = cnt_q;

    // ==========================================================
    // memory side gating
    // ==========================================================
    logic [7:0] maddr_q;
    logic [7:0] maddr_d;
    logic [7:0] mdata_q;
    logic [7:0] mdata_d;
    logic [2:0] msel_q;
    logic [2:0] msel_d;
    logic       mstby_q;
    logic       mstby_d;
    logic       mem_off;

    assign mem_off = pd_d | ~cs_low;

    always_comb begin
        maddr_d = gate_byte(pd_d, addr_s, maddr_q);
        mdata_d = gate_byte(pd_d, data_s, mdata_q);
        msel_d  = mem_off ? 3'h0
                : {sram_req_i, secondary_flash_req_i, primary_flash_req_i};
        mstby_d = mem_off;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            maddr_q <= BYTE_RESET;
            mdata_q <= BYTE_RESET;
            msel_q  <= SEL_RESET;
            mstby_q <= STBY_RESET;
        end else begin
            maddr_q <= maddr_d;
            mdata_q <= mdata_d;
            msel_q  <= msel_d;
            mstby_q <= mstby_d;
        end
    end

    assign mem_addr_o            = maddr_q;
    assign mem_data_o            = mdata_q;
    assign primary_flash_sel_o   = msel_q[0];
    assign secondary_flash_sel_o = msel_q[1];
    assign sram_sel_o            = msel_q[2];
    assign mem_standby_o         = mstby_q;

    // ==========================================================
    // pld input gating
    // ==========================================================
    // vector: clk_mcell, clk_and, benable, strobe, ctrl[2:0], addr[7:0]
    logic [14:0] pin_q;
    logic [14:0] pin_d;
    logic        turbo_q;
    logic        turbo_d;

    always_comb begin
        pin_d[7:0] = gate_byte(pd_d | power_mode_reg_two_i[PMR2_ADDR_LOW],
                               addr_s, pin_q[7:0]);
        pin_d[8]   = gate_bit(power_mode_reg_two_i[PMR2_CTRL_ZERO],
                              ctrl_s[0], pin_q[8]);
        pin_d[9]   = gate_bit(power_mode_reg_two_i[PMR2_CTRL_ONE],
                              ctrl_s[1], pin_q[9]);
        pin_d[10]  = gate_bit(power_mode_reg_two_i[PMR2_CTRL_TWO],
                              ctrl_s[2], pin_q[10]);
        pin_d[11]  = gate_bit(power_mode_reg_two_i[PMR2_STROBE],
                              strobe_s, pin_q[11]);
        pin_d[12]  = gate_bit(power_mode_reg_two_i[PMR2_BYTE_EN],
                              benable_s, pin_q[12]);
        pin_d[13]  = gate_bit(power_mode_reg_zero_i[PMR0_CLK_ANDARR],
                              pclk_s, pin_q[13]);
        pin_d[14]  = gate_bit(power_mode_reg_zero_i[PMR0_CLK_MCELL],
                              pclk_s, pin_q[14]);
        turbo_d    = power_mode_reg_zero_i[PMR0_TURBO_OFF];
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_q   <= PLD_IN_RESET;
            turbo_q <= BIT_RESET;
        end else begin
            pin_q   <= pin_d;
            turbo_q <= turbo_d;
        end
    end

    assign pld_addr_low_o     = pin_q[7:0];
    assign pld_control_zero_o = pin_q[8];
    assign pld_control_one_o  = pin_q[9];
    assign pld_control_two_o  = pin_q[10];
    assign pld_strobe_o       = pin_q[11];
    assign pld_byte_enable_o  = pin_q[12];
    assign pld_and_clock_o    = pin_q[13];
    assign pld_mcell_clock_o  = pin_q[14];
    assign pld_turbo_off_o    = turbo_q;

    // ==========================================================
    // pld quiet tracking
    // ==========================================================
    // composite input activity only; blocked inputs never count
    logic [3:0] quiet_q;
    logic [3:0] quiet_d;
    logic       stby_q;
    logic       stby_d;
    logic       slow_q;
    logic       slow_d;

    always_comb begin
        quiet_d = quiet_q;
        if (pin_d != pin_q) begin
            quiet_d = 4'h0;
        end else if (quiet_q != QUIET_MAX) begin
            quiet_d = quiet_q + 4'h1;
        end
        stby_d = turbo_d & (quiet_d >= PLD_QUIET_CYC);
        slow_d = turbo_d & (quiet_d >= PLD_SLOW_CYC);
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            quiet_q <= QUIET_RESET;
            stby_q  <= BIT_RESET;
            slow_q  <= BIT_RESET;
        end else begin
            quiet_q <= quiet_d;
            stby_q  <= stby_d;
            slow_q  <= slow_d;
        end
    end

    assign pld_standby_o    = stby_q;
    assign pld_slow_delay_o = slow_q;

    // ==========================================================
    // port pins
    // ==========================================================
    logic [7:0] dout_q;
    logic [7:0] dout_d;
    logic       doe_n_q;
    logic       doe_n_d;
    logic [7:0] pout_q;
    logic [7:0] pout_d;
    logic       poe_n_q;
    logic       poe_n_d;
    logic [7:0] aout_q;
    logic [7:0] aout_d;
    logic [7:0] gpio_q;
    logic [7:0] gpio_d;
    logic [7:0] pldp_q;
    logic [7:0] pldp_d;

    always_comb begin
        dout_d  = mem_rdata_i;
        pout_d  = periph_out_i;
        doe_n_d = ~(data_drive_i & ~pd_d);
        poe_n_d = ~(periph_drive_i & ~pd_d);
        // address out undefined while down: frozen here
        aout_d  = gate_byte(pd_d, latched_addr_i, aout_q);
        gpio_d  = gpio_out_i;
        pldp_d  = pld_out_i;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_q  <= BYTE_RESET;
            doe_n_q <= OE_N_RESET;
            pout_q  <= BYTE_RESET;
            poe_n_q <= OE_N_RESET;
            aout_q  <= BYTE_RESET;
            gpio_q  <= BYTE_RESET;
            pldp_q  <= BYTE_RESET;
        end else begin
            dout_q  <= dout_d;
            doe_n_q <= doe_n_d;
            pout_q  <= pout_d;
            poe_n_q <= poe_n_d;
            aout_q  <= aout_d;
            gpio_q  <= gpio_d;
            pldp_q  <= pldp_d;
        end
    end

    assign data_port_out_o  = dout_q;
    assign data_port_oe_n_o = doe_n_q;
    assign periph_io_out_o  = pout_q;
    assign periph_io_oe_n_o = poe_n_q;
    assign address_out_o    = aout_q;
    assign gpio_pin_o       = gpio_q;
    assign pld_pin_o        = pldp_q;

endmodule

// file: core/apu_pkg.sv
package apu_pkg;

    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int        MCLK_MHZ       = 125;
    localparam int        PLD_QUIET_NS   = 70;
    localparam int        PLD_SLOW_MHZ   = 15;
    // least time: round up
    localparam int        QUIET_CYC_RAW  = (PLD_QUIET_NS * MCLK_MHZ + 999) / 1000;
    // longest time: round down
    localparam int        SLOW_CYC_RAW   = MCLK_MHZ / PLD_SLOW_MHZ;
    localparam logic [3:0] PLD_QUIET_CYC =
        4'((QUIET_CYC_RAW < 1) ? 1 : QUIET_CYC_RAW);
    localparam logic [3:0] PLD_SLOW_CYC  =
        4'((SLOW_CYC_RAW < 1) ? 1 : SLOW_CYC_RAW);
    localparam logic [3:0] QUIET_MAX     = 4'hF;

    // ==========================================================
    // idle counter
    // ==========================================================
    localparam int         IDLE_W        = 4;
    localparam logic [3:0] IDLE_LIMIT    = 4'hF;
    localparam logic [3:0] IDLE_RESET    = 4'h0;

    // ==========================================================
    // power mode register 0 fields
    // ==========================================================
    localparam int PMR0_TURBO_OFF  = 3;
    localparam int PMR0_CLK_ANDARR = 4;
    localparam int PMR0_CLK_MCELL  = 5;

    // ==========================================================
    // power mode register 2 fields
    // ==========================================================
    localparam int PMR2_ADDR_LOW   = 0;
    localparam int PMR2_CTRL_ZERO  = 2;
    localparam int PMR2_CTRL_ONE   = 3;
    localparam int PMR2_CTRL_TWO   = 4;
    localparam int PMR2_STROBE     = 5;
    localparam int PMR2_BYTE_EN    = 6;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0] BYTE_RESET    = 8'h00;
    localparam logic       BIT_RESET     = 1'b0;
    localparam logic       OE_N_RESET    = 1'b1;
    // sync stages start at strobe high, pld clock low, select high
    localparam logic [2:0]  PIN_SYNC_RESET = 3'h5;
    localparam logic [1:0]  PIN_EDGE_RESET = 2'h1;
    localparam logic [19:0] BUS_SYNC_RESET = 20'h00000;
    localparam logic [14:0] PLD_IN_RESET   = 15'h0800;
    localparam logic [2:0]  SEL_RESET      = 3'h0;
    localparam logic        STBY_RESET     = 1'h1;
    localparam logic [3:0]  QUIET_RESET    = 4'h0;

    typedef enum logic {
        APU_RUN,
        APU_DOWN
    } apu_mode_e;

endpackage

// file: core/apu_idle_cnt.sv
`timescale 1ns/1ps

module apu_idle_cnt
    import apu_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              clear_i,
    input  wire logic              tick_i,
    output logic [IDLE_W-1:0]      count_o,
    output logic                   full_o
);

    // ==========================================================
    // counter
    // ==========================================================
    logic [IDLE_W-1:0] count_q;
    logic [IDLE_W-1:0] count_d;
    logic              full_q;
    logic              full_d;

    always_comb begin
        count_d = count_q;
        if (clear_i) begin
            count_d = IDLE_RESET;
        end else if (tick_i && (count_q != IDLE_LIMIT)) begin
            count_d = count_q + 4'h1;
        end
        full_d = (count_d == IDLE_LIMIT);
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= IDLE_RESET;
            full_q  <= BIT_RESET;
        end else begin
            count_q <= count_d;
            full_q  <= full_d;
        end
    end

    assign count_o = count_q;
    assign full_o  = full_q;

endmodule

// file: sim/apu_checker.sv
`timescale 1ns/1ps

// ========================
// power-down checker
// ========================
module apu_checker
    import apu_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic       address_strobe_in_i,
    input wire logic       chip_select_n_i,
    input wire logic       auto_powerdown_enable_bit_i,
    input wire logic [7:0] power_mode_reg_zero_i,
    input wire logic [7:0] power_mode_reg_two_i,
    input wire logic       powerdown_flag_o,
    input wire logic [3:0] idle_count_o,
    input wire logic       sram_sel_o,
    input wire logic       mem_standby_o,
    input wire logic       pld_strobe_o,
    input wire logic       pld_and_clock_o,
    input wire logic       pld_mcell_clock_o,
    input wire logic       pld_turbo_off_o,
    input wire logic       data_port_oe_n_o,
    input wire logic       periph_io_oe_n_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    a_flag_full_count: assert property (
        $rose(powerdown_flag_o) |-> idle_count_o == IDLE_LIMIT)
        else $error("flag rose early");
    a_down_deselects: assert property (
        powerdown_flag_o && $past(powerdown_flag_o) |-> !sram_sel_o && mem_standby_o)
        else $error("memory live while down");
    a_down_tristate: assert property (
        powerdown_flag_o && $past(powerdown_flag_o) |-> data_port_oe_n_o && periph_io_oe_n_o)
        else $error("pins driven while down");
    a_strobe_wakes: assert property (
        powerdown_flag_o && address_strobe_in_i != $past(address_strobe_in_i)
        |-> ##[1:5] !powerdown_flag_o) else $error("strobe did not wake");
    a_cs_wakes: assert property (
        powerdown_flag_o && !chip_select_n_i |-> ##[1:5] !powerdown_flag_o)
        else $error("select did not wake");
    a_cs_high_off: assert property (
        $past(chip_select_n_i, 3) |-> mem_standby_o && !sram_sel_o)
        else $error("memory live while unselected");
    a_off_no_count: assert property (
        !$past(auto_powerdown_enable_bit_i, 2) |-> idle_count_o == 4'h0)
        else $error("count while disabled");
    a_turbo_follows: assert property (
        !$past(rst_i) |-> pld_turbo_off_o == $past(power_mode_reg_zero_i[3]))
        else $error("turbo output wrong");
    a_strobe_frozen: assert property (
        $past(power_mode_reg_two_i[5]) |-> $stable(pld_strobe_o))
        else $error("blocked strobe moved");
    a_clock_frozen: assert property (
        $past(power_mode_reg_zero_i[4]) |-> $stable(pld_and_clock_o))
        else $error("blocked clock moved");
    a_mcell_frozen: assert property (
        $past(power_mode_reg_zero_i[5]) |-> $stable(pld_mcell_clock_o))
        else $error("blocked macrocell clock moved");
endmodule

bind apu_top apu_checker u_apu_checker (
    .mclk_i, .rst_i, .address_strobe_in_i, .chip_select_n_i,
    .auto_powerdown_enable_bit_i, .power_mode_reg_zero_i, .power_mode_reg_two_i,
    .powerdown_flag_o, .idle_count_o, .sram_sel_o, .mem_standby_o, .pld_strobe_o,
    .pld_and_clock_o, .pld_mcell_clock_o, .pld_turbo_off_o, .data_port_oe_n_o,
    .periph_io_oe_n_o);

// file: sim/apu_mcu_model.sv
`timescale 1ns/1ps

// ========================
// mcu bus side model
// ========================
module apu_mcu_model #(
    parameter int HALF = 4
) (
    input  wire logic       mclk_i,
    input  wire logic       pulse_i,
    input  wire logic       rest_i,
    input  wire logic       clk_run_i,
    output logic            strobe_o,
    output logic            pld_clk_o,
    output logic [7:0]      bus_o
);
    int ph = 0;

    initial begin
        strobe_o = 1'b1;
        pld_clk_o = 1'b0;
        bus_o = 8'h00;
    end

    always @(posedge mclk_i) begin
        strobe_o <= pulse_i ? ~strobe_o : rest_i;
        // other bus users keep lines moving, so blocking is visible
        bus_o <= bus_o + 8'h01;
        // clock stands low between runs, restarts at a fixed phase
        ph <= clk_run_i ? ph + 1 : 0;
        pld_clk_o <= clk_run_i && ((ph % (2 * HALF)) >= HALF);
    end
endmodule

// file: sim/apu_top_tb.sv
`timescale 1ns/1ps

// ========================
// power-down bench
// ========================
module apu_top_tb;
    // first rise, fourteen periods of 8, then sync and flag latency
    localparam int T_ENTRY = 4 + 14 * 8 + 6;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       cs_n = 1'b1;
    logic       en = 1'b0;
    logic       pol = 1'b1;
    logic       rest = 1'b1;
    logic       pulse = 1'b0;
    logic       run = 1'b0;
    logic       req = 1'b0;
    logic [7:0] reg0 = 8'h00;
    logic [7:0] reg2 = 8'h00;
    logic       strobe, pclk, flag, sel, stby, d_oe_n, p_oe_n, turbo, pstby, slow;
    logic [7:0] bus, maddr, gpio, pldp, held;
    logic [3:0] idle;
    int         miscompares = 0;
    int         n_compared = 0;
    int         n;

    always #4 mclk = ~mclk;

    apu_mcu_model u_apu_mcu_model (.mclk_i(mclk), .pulse_i(pulse), .rest_i(rest),
        .clk_run_i(run), .strobe_o(strobe), .pld_clk_o(pclk), .bus_o(bus));

    apu_top u_apu_top (.mclk_i(mclk), .rst_i(rst), .address_strobe_in_i(strobe),
        .pld_clock_input_i(pclk), .chip_select_n_i(cs_n), .mcu_addr_low_i(bus),
        .mcu_data_i(~bus), .control_input_zero_i(bus[0]), .control_input_one_i(bus[1]),
        .control_input_two_i(bus[2]), .byte_enable_input_i(bus[3]),
        .auto_powerdown_enable_bit_i(en), .strobe_idle_polarity_i(pol),
        .power_mode_reg_zero_i(reg0), .power_mode_reg_two_i(reg2),
        .primary_flash_req_i(req), .secondary_flash_req_i(req), .sram_req_i(req),
        .data_drive_i(req), .mem_rdata_i(bus), .periph_drive_i(req), .periph_out_i(~bus),
        .latched_addr_i(bus), .gpio_out_i(bus), .pld_out_i(~bus),
        .powerdown_flag_o(flag), .idle_count_o(idle), .mem_addr_o(maddr), .mem_data_o(),
        .primary_flash_sel_o(), .secondary_flash_sel_o(), .sram_sel_o(sel),
        .mem_standby_o(stby), .pld_addr_low_o(), .pld_control_zero_o(),
        .pld_control_one_o(), .pld_control_two_o(), .pld_strobe_o(), .pld_byte_enable_o(),
        .pld_and_clock_o(), .pld_mcell_clock_o(), .pld_turbo_off_o(turbo),
        .pld_standby_o(pstby), .pld_slow_delay_o(slow), .data_port_out_o(),
        .data_port_oe_n_o(d_oe_n), .periph_io_out_o(), .periph_io_oe_n_o(p_oe_n),
        .address_out_o(), .gpio_pin_o(gpio), .pld_pin_o(pldp));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_flag(input logic v, input int lim, output int k);
        k = 0;
        while (flag !== v && k < lim) begin
            @(negedge mclk);
            k++;
        end
    endtask

    task automatic arm(input logic p, input logic lvl, input logic e);
        @(posedge mclk);
        run <= 1'b0;
        pol <= p;
        rest <= lvl;
        en <= e;
        repeat (4) @(posedge mclk);
        run <= 1'b1;
        @(negedge mclk);
    endtask

    task automatic t_entry();
        @(posedge mclk);
        reg0 <= 8'h38;
        reg2 <= 8'h7D;
        req <= 1'b1;
        arm(1'b1, 1'b1, 1'b1);
        wait_flag(1'b1, 200, n);
        chk(8'(n >= T_ENTRY - 3 && n <= T_ENTRY + 3), 8'h01);
        repeat (20) @(negedge mclk);
        chk({6'h00, sel, stby}, 8'h01);
        chk({6'h00, d_oe_n, p_oe_n}, 8'h03);
        chk({5'h00, turbo, pstby, slow}, 8'h07);
        chk(gpio, bus - 8'h01);
        chk(pldp, ~(bus - 8'h01));
        held = maddr;
        repeat (4) @(negedge mclk);
        chk(maddr, held);
        @(posedge mclk);
        pulse <= 1'b1;
        repeat (2) @(posedge mclk);
        pulse <= 1'b0;
        wait_flag(1'b0, 8, n);
        chk(8'(n < 8), 8'h01);
    endtask

    task automatic t_restart();
        arm(1'b1, 1'b1, 1'b1);
        repeat (60) @(posedge mclk);
        reg0 <= 8'h00;
        pulse <= 1'b1;
        repeat (2) @(posedge mclk);
        pulse <= 1'b0;
        repeat (5) @(negedge mclk);
        chk({4'h0, idle}, 8'h00);
        chk(8'(turbo), 8'h00);
        wait_flag(1'b1, 200, n);
        chk(8'(n > 100), 8'h01);
        @(posedge mclk);
        cs_n <= 1'b0;
        wait_flag(1'b0, 8, n);
        chk(8'(n < 8), 8'h01);
        repeat (3) @(negedge mclk);
        chk({6'h00, sel, stby}, 8'h02);
        @(posedge mclk);
        cs_n <= 1'b1;
        repeat (5) @(negedge mclk);
        chk({6'h00, sel, stby}, 8'h01);
    endtask

    task automatic t_no_count();
        arm(1'b1, 1'b0, 1'b1);
        repeat (150) @(negedge mclk);
        chk({3'h0, flag, idle}, 8'h00);
        arm(1'b1, 1'b1, 1'b0);
        repeat (150) @(negedge mclk);
        chk({3'h0, flag, idle}, 8'h00);
        arm(1'b0, 1'b0, 1'b1);
        wait_flag(1'b1, 200, n);
        chk(8'(n >= T_ENTRY - 3 && n <= T_ENTRY + 3), 8'h01);
    endtask

    task automatic t_reset_exit();
        @(posedge mclk);
        rst <= 1'b1;
        #1;
        chk({6'h00, flag, stby}, 8'h01);
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(negedge mclk);
        chk({2'h0, flag, stby, idle}, 8'h10);
    endtask

    task automatic conclude();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk({6'h00, flag, stby}, 8'h01);
        t_entry();
        t_restart();
        t_no_count();
        t_reset_exit();
        conclude();
    end

    // about four times the expected run
    initial begin
        #(8 * 3000);
        miscompares++;
        conclude();
    end
endmodule
